// File: hw/call_param_regs.svh
`ifndef CALL_PARAM_REGS_SVH
`define CALL_PARAM_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_CUG       8'h04
`define OFS_CUG_ENC   8'h08
`define OFS_CUG_STAT  8'h0c
`define OFS_FCI       8'h10
`define OFS_EVT       8'h14
`define OFS_INFO      8'h18
`define OFS_CONT      8'h1c
`define OFS_FAC       8'h20
`define OFS_LREF      8'h24
`define OFS_CREQ      8'h28
`define OFS_OPT       8'h2c
`define OFS_OPT_STAT  8'h30
`define OFS_CNUM      8'h34

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define CTRL_INTL_IN      0
`define CTRL_OCT2_UNUSED  1
`define CNUM_PRES_LSB     2
`define CNUM_PRES_NOT_AVAIL 2'h2
`define CNUM_HDR_OCTETS   5'h02
`define FAC_USER_TO_USER  8'h02
`define EVT_LAST_KNOWN    7'h06
`define END_OF_OPT_OCTET  8'h00

// ----------------------------------------------------------------
// Masks of bits that are sent, everything else goes out as zero
// ----------------------------------------------------------------
`define FCI_SENT_MASK     16'hf7ff
`define FCI_LOCAL_MASK    16'h07ff
`define INFO_SENT_MASK    16'h00e7
`define CONT_SENT_MASK    8'h01

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_WORD32        32'h0000_0000
`define RST_CTRL          2'h0

`endif

// File: hw/call_param_pkg.sv
package call_param_pkg;

    typedef enum logic [1:0] {
        E2E_LINK_ONLY, E2E_PASS_ALONG, E2E_CCP, E2E_BOTH
    } e2e_method_t;

    typedef struct packed {
        logic [3:0]  national_use;
        logic        spare_l;
        logic [1:0]  ccp_method;
        logic        isdn_access;
        logic [1:0]  up_pref;
        logic        up_used;
        logic        e2e_info;
        logic        interworking;
        e2e_method_t e2e_method;
        logic        international;
    } fci_t;

    typedef struct packed {
        logic [3:0] d4;
        logic [3:0] d3;
        logic [3:0] d2;
        logic [3:0] d1;
    } net_identity_digits_t;

endpackage

// File: hw/call_param_codec.sv
// Functional notes
// [R01] Identity digits are BCD values zero to nine
// [R02] Lead 0 or 9: country code follows
// [R03] Unneeded second identity octet sent as zeros
// [R04] Lead 1 or 8 forbidden; others mean data-net
// [R05] Group code: octets three-four, unsigned, MSB first
// [R06] Address unavailable: omit octets three onward
// [R07] Connection request: reference, point code, class, credit
// [R08] Continuity bit A: one success, zero failure
// [R09] Zero octet ends optional parameter list
// [R10] Seven-bit event codes one to six defined
// [R11] Event bit H marks presentation restricted
// [R12] Facility value 00000010 means user-to-user
// [R13] International bit set on incoming international calls
// [R14] End-to-end method field, bits C,B
// [R15] Bits D,E,F: interworking, info, user part
// [R16] User-part preference H,G; 11 spare
// [R17] Bit I access; bits K,J method
// [R18] Protocol control group B-F, J-K; L spare
// [R19] Calling address response B,A; 10 spare
// [R20] Hold C, category F, charge G flags
// [R21] Bit H unsolicited; bits I-P spare
// [R22] Spares sent zero, ignored on receive
`include "call_param_regs.svh"

module call_param_codec #(
    parameter int POINT_CODE_W = 14
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic bad_bcd(input logic [3:0] d);
        return d > 4'h9;
    endfunction

    // ----------------------------------------------------------------
    // Bus access
    // ----------------------------------------------------------------
    logic req;
    logic wr;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;

    // Byte lanes kept from the old value and bytes taken from the bus
    logic [31:0] keep;
    logic [31:0] put;
    assign keep = ~{{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign put = wb_dat_i & ~keep;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [1:0]  ctrl_reg;
    logic [31:0] cug_reg;
    logic [15:0] fci_reg;
    logic [7:0]  evt_reg;
    logic [15:0] info_reg;
    logic [7:0]  cont_reg;
    logic [7:0]  fac_reg;
    logic [23:0] lref_reg;
    logic [31:0] creq_reg;
    logic [20:0] cnum_reg;
    logic        end_seen_reg;
    logic [7:0]  opt_cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `RST_CTRL;
            cug_reg <= `RST_WORD32;
            fci_reg <= 16'h0000;
            evt_reg <= 8'h00;
            info_reg <= 16'h0000;
            cont_reg <= 8'h00;
            fac_reg <= 8'h00;
            lref_reg <= 24'h000000;
            creq_reg <= `RST_WORD32;
            cnum_reg <= 21'h000000;
        end else if (wr) begin
            if (hit(wb_adr_i, `OFS_CTRL)) ctrl_reg <= (ctrl_reg & keep[1:0]) | put[1:0];
            if (hit(wb_adr_i, `OFS_CUG)) cug_reg <= merge(cug_reg, wb_dat_i, wb_sel_i);
            if (hit(wb_adr_i, `OFS_FCI)) fci_reg <= (fci_reg & keep[15:0]) | put[15:0];
            if (hit(wb_adr_i, `OFS_EVT)) evt_reg <= (evt_reg & keep[7:0]) | put[7:0];
            if (hit(wb_adr_i, `OFS_INFO)) info_reg <= (info_reg & keep[15:0]) | put[15:0];
            if (hit(wb_adr_i, `OFS_CONT)) cont_reg <= (cont_reg & keep[7:0]) | put[7:0];
            if (hit(wb_adr_i, `OFS_FAC)) fac_reg <= (fac_reg & keep[7:0]) | put[7:0];
            if (hit(wb_adr_i, `OFS_LREF)) lref_reg <= (lref_reg & keep[23:0]) | put[23:0];
            if (hit(wb_adr_i, `OFS_CREQ)) creq_reg <= merge(creq_reg, wb_dat_i, wb_sel_i);
            if (hit(wb_adr_i, `OFS_CNUM)) cnum_reg <= (cnum_reg & keep[20:0]) | put[20:0];
        end
    end

    // ----------------------------------------------------------------
    // Optional parameter scanner
    // ----------------------------------------------------------------
    logic opt_wr;
    logic opt_clr;
    assign opt_wr = wr & hit(wb_adr_i, `OFS_OPT) & wb_sel_i[0];
    assign opt_clr = wr & hit(wb_adr_i, `OFS_OPT_STAT) & wb_sel_i[0] & wb_dat_i[0];

    // A zero octet ends the list; later octets are not counted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            end_seen_reg <= 1'b0;
            opt_cnt_reg <= 8'h00;
        end else if (opt_wr && !end_seen_reg) begin
            if (wb_dat_i[7:0] == `END_OF_OPT_OCTET) begin
                end_seen_reg <= 1'b1; // R09
            end else begin
                opt_cnt_reg <= opt_cnt_reg + 8'h01;
            end
        end else if (opt_clr) begin
            end_seen_reg <= 1'b0;
            opt_cnt_reg <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Closed group interlock code
    // ----------------------------------------------------------------
    call_param_pkg::net_identity_digits_t net_identity_digits;
    logic [3:0]  digit_err;
    logic        lead_forbidden;
    logic        is_country;
    logic        is_data_net;
    logic [11:0] country_code_digits;
    logic [15:0] data_net_id_code;
    logic [15:0] closed_group_code;
    logic [31:0] cug_enc;

    assign net_identity_digits = cug_reg[15:0];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bcd
            assign digit_err[g] = bad_bcd(cug_reg[g*4 +: 4]); // R01
        end
    endgenerate

    assign lead_forbidden = net_identity_digits.d1 == 4'h1
                          || net_identity_digits.d1 == 4'h8; // R04
    assign is_country = net_identity_digits.d1 == 4'h0
                      || net_identity_digits.d1 == 4'h9; // R02
    assign is_data_net = !is_country && !lead_forbidden && !digit_err[0]; // R04
    assign country_code_digits = {net_identity_digits.d2, net_identity_digits.d3,
                                  net_identity_digits.d4}; // R02
    assign data_net_id_code = is_data_net ? cug_reg[15:0] : 16'h0000;
    // Bit 8 of octet three is the top bit of the group code
    assign closed_group_code = {cug_reg[23:16], cug_reg[31:24]}; // R05
    assign cug_enc = {cug_reg[31:16],
                      ctrl_reg[`CTRL_OCT2_UNUSED] ? 8'h00 : cug_reg[15:8], // R03
                      cug_reg[7:0]};

    // ----------------------------------------------------------------
    // Forward call indicators
    // ----------------------------------------------------------------
    call_param_pkg::fci_t fci_enc;
    logic [6:0] pci_group;
    always_comb begin
        fci_enc = fci_reg & `FCI_SENT_MASK; // R22
        fci_enc.spare_l = 1'b0; // R18
        if (ctrl_reg[`CTRL_INTL_IN]) begin
            fci_enc.international = 1'b1; // R13
        end
    end
    // Decoded fields of the received word; bit A is reported, never checked
    call_param_pkg::fci_t fci_rx;
    assign fci_rx = fci_reg; // R13
    assign pci_group = {fci_rx.ccp_method, fci_rx.up_used, fci_rx.e2e_info,
                        fci_rx.interworking, fci_rx.e2e_method}; // R18
    logic [7:0] fci_flags;
    assign fci_flags = {fci_rx.up_pref == 2'h3,                         // R16
                        fci_rx.ccp_method == 2'h3, fci_rx.isdn_access,  // R17
                        fci_rx.up_used, fci_rx.e2e_info, fci_rx.interworking, // R15
                        fci_rx.e2e_method == call_param_pkg::E2E_BOTH,  // R14
                        fci_rx.e2e_method == call_param_pkg::E2E_LINK_ONLY}; // R14

    // ----------------------------------------------------------------
    // Event, facility, continuity, information indicators
    // ----------------------------------------------------------------
    logic       evt_known;
    logic [6:0] evt_code;
    assign evt_code = evt_reg[6:0];
    assign evt_known = evt_code != 7'h00 && evt_code <= `EVT_LAST_KNOWN; // R10
    logic evt_restricted;
    assign evt_restricted = evt_reg[7]; // R11

    logic fac_u2u;
    assign fac_u2u = fac_reg == `FAC_USER_TO_USER; // R12

    logic cont_ok;
    assign cont_ok = cont_reg[0]; // R08

    logic [15:0] info_enc;
    logic [6:0]  info_flags;
    assign info_enc = info_reg & `INFO_SENT_MASK; // R21
    assign info_flags = {info_reg[7],                          // R21
                         info_reg[6], info_reg[5], info_reg[2], // R20
                         info_reg[1:0] == 2'h2,                 // R19
                         info_reg[1:0] == 2'h1,                 // R19
                         info_reg[1:0] == 2'h3};                // R19

    // ----------------------------------------------------------------
    // Connected number and connection request
    // ----------------------------------------------------------------
    logic       cnum_no_addr;
    logic [4:0] cnum_len;
    logic [4:0] digit_octets;
    assign cnum_no_addr = cnum_reg[8 + `CNUM_PRES_LSB +: 2] == `CNUM_PRES_NOT_AVAIL;
    // Six bits so that a count of 31 still rounds up to 16 octets
    assign digit_octets = 5'((6'(cnum_reg[20:16]) + 6'h01) >> 1);
    assign cnum_len = cnum_no_addr ? `CNUM_HDR_OCTETS
                                   : 5'(`CNUM_HDR_OCTETS + digit_octets); // R06

    logic [POINT_CODE_W-1:0] point_code;
    assign point_code = creq_reg[POINT_CODE_W-1:0]; // R07

    // ----------------------------------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------------------------------
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            `OFS_CTRL:     rd_data = 32'(ctrl_reg);
            `OFS_CUG:      rd_data = cug_reg;
            `OFS_CUG_ENC:  rd_data = cug_enc;
            `OFS_CUG_STAT: rd_data = {closed_group_code, data_net_id_code[7:0], is_data_net,
                                      is_country, lead_forbidden, 1'b0, digit_err};
            `OFS_FCI:      rd_data = {fci_flags, 1'b0, pci_group, 16'(fci_enc)};
            `OFS_EVT:      rd_data = {22'h000000, evt_known, evt_restricted, evt_reg};
            `OFS_INFO:     rd_data = {9'h000, info_flags, info_enc};
            `OFS_CONT:     rd_data = {23'h000000, cont_ok, cont_reg & `CONT_SENT_MASK};
            `OFS_FAC:      rd_data = {23'h000000, fac_u2u, fac_reg};
            `OFS_LREF:     rd_data = 32'(lref_reg);
            `OFS_CREQ:     rd_data = {creq_reg[31:POINT_CODE_W], point_code};
            `OFS_OPT:      rd_data = 32'(`END_OF_OPT_OCTET);
            `OFS_OPT_STAT: rd_data = {23'h000000, opt_cnt_reg, end_seen_reg};
            `OFS_CNUM:     rd_data = {3'h0, cnum_len, 2'h0, cnum_no_addr, cnum_reg};
            default:       rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_single;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

    property p_bcd_flag;
        wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == `OFS_CUG_STAT && cug_reg[3:0] > 4'h9
            && !wb_ack_o |=> wb_dat_o[0];
    endproperty
    a_bcd_flag: assert property (p_bcd_flag) else $error("bad digit not flagged"); // R01

    property p_oct2_zero;
        ctrl_reg[`CTRL_OCT2_UNUSED] |-> cug_enc[15:8] == 8'h00;
    endproperty
    a_oct2_zero: assert property (p_oct2_zero) else $error("octet 2 not zeroed"); // R03

    property p_lead_forbid;
        (cug_reg[3:0] == 4'h1 || cug_reg[3:0] == 4'h8) |-> lead_forbidden && !is_data_net;
    endproperty
    a_lead_forbid: assert property (p_lead_forbid) else $error("forbidden lead digit"); // R04

    property p_end_opt;
        opt_wr && !end_seen_reg && wb_dat_i[7:0] == 8'h00
            |=> end_seen_reg && $stable(opt_cnt_reg);
    endproperty
    a_end_opt: assert property (p_end_opt) else $error("end octet not seen"); // R09

    property p_intl_bit;
        ctrl_reg[`CTRL_INTL_IN] |-> fci_enc[0] && fci_enc[11] == 1'b0;
    endproperty
    a_intl_bit: assert property (p_intl_bit) else $error("international bit not forced"); // R13

    property p_evt_known;
        evt_known |-> evt_reg[6:0] inside {[7'h01:7'h06]};
    endproperty
    a_evt_known: assert property (p_evt_known) else $error("event decode wrong"); // R10

    property p_u2u;
        fac_u2u |-> fac_reg == 8'h02;
    endproperty
    a_u2u: assert property (p_u2u) else $error("facility decode wrong"); // R12

    property p_no_addr;
        cnum_no_addr |-> cnum_len == 5'h02;
    endproperty
    a_no_addr: assert property (p_no_addr) else $error("address octets kept"); // R06

    property p_info_spare;
        info_enc[15:8] == 8'h00 && info_enc[4:3] == 2'h0;
    endproperty
    a_info_spare: assert property (p_info_spare) else $error("info spare bit sent"); // R22

    c_read: cover property (req && !wb_we_i ##1 wb_ack_o);
    c_end_opt: cover property (opt_wr ##1 end_seen_reg);
    c_intl: cover property (ctrl_reg[`CTRL_INTL_IN] && fci_reg[0] == 1'b0);
    c_no_addr: cover property (cnum_no_addr && cnum_reg[20:16] != 5'h00);

endmodule

// File: verification/peer_exchange_model.sv
module peer_exchange_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Message stepping
    input wire logic next_i,
    input wire logic last_i,
    // Received field octets
    output logic [7:0] evt_o,
    output logic [15:0] fci_o,
    output logic [7:0] cont_o,
    output logic [7:0] opt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] st_reg;
    logic [2:0] code;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= 16'hace1;
        end else if (next_i) begin
            st_reg <= {st_reg[14:0], st_reg[15] ^ st_reg[13] ^ st_reg[12] ^ st_reg[10]};
        end
    end

    assign code = (st_reg[2:0] > 3'h5) ? st_reg[2:0] - 3'h5 : st_reg[2:0] + 3'h1;
    assign evt_o = {st_reg[7], 4'h0, code};
    assign fci_o = {4'h0, 1'b0, st_reg[10:0]};
    assign cont_o = {7'h00, st_reg[4]};
    // Zero octet closes the optional list, every other octet is nonzero
    assign opt_o = last_i ? 8'h00 : {st_reg[15:9], 1'b1};
endmodule

// File: verification/tb.sv
`include "call_param_regs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, next_r, last_r, opt_end;
    logic [7:0] wb_adr_i, evt_w, cont_w, opt_w, opt_cnt;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, seed, rd_q;
    logic [15:0] fci_w;
    logic [31:0] sh [0:15];
    int miscompares, compares;

    call_param_codec #(.POINT_CODE_W(14)) call_param_codec_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    peer_exchange_model peer_exchange_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .next_i(next_r), .last_i(last_r),
        .evt_o(evt_w), .fci_o(fci_w), .cont_o(cont_w), .opt_o(opt_w));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // Expected values
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction

    function automatic logic [31:0] wmask(input logic [7:0] a);
        case (a)
            8'h00: return 32'h0000_0003;
            8'h04, 8'h28: return 32'hffff_ffff;
            8'h10, 8'h18: return 32'h0000_ffff;
            8'h14, 8'h1c, 8'h20: return 32'h0000_00ff;
            8'h24: return 32'h00ff_ffff;
            8'h34: return 32'h001f_ffff;
            default: return 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] exp_read(input logic [7:0] a);
        logic [31:0] v, r, g;
        logic [5:0] n;
        v = sh[a[5:2]];
        g = sh[1];
        r = 32'h0;
        n = {1'b0, v[20:16]} + 6'h01;
        case (a)
            8'h00, 8'h04, 8'h24, 8'h28: r = v;
            8'h08: r = sh[0][1] ? (g & 32'hffff_00ff) : g;
            8'h0c: begin
                for (int i = 0; i < 4; i++) r[i] = (g[4*i +: 4] > 4'h9);
                r[5] = (g[3:0] == 4'h1) || (g[3:0] == 4'h8);
                r[6] = (g[3:0] == 4'h0) || (g[3:0] == 4'h9);
                r[7] = (g[3:0] <= 4'h9) && !r[5] && !r[6];
                r[15:8] = r[7] ? g[7:0] : 8'h00;
                r[31:16] = {g[23:16], g[31:24]};
            end
            8'h10: begin
                r[15:0] = (v[15:0] & 16'hf7ff) | {15'h0, sh[0][0]};
                r[22:16] = {v[10:9], v[5:1]};
                r[24] = v[2:1] == 2'h0;
                r[25] = v[2:1] == 2'h3;
                r[28:26] = v[5:3];
                r[29] = v[8];
                r[30] = v[10:9] == 2'h3;
                r[31] = v[7:6] == 2'h3;
            end
            8'h14: r = {22'h0, (v[6:0] >= 7'h01) && (v[6:0] <= 7'h06), v[7], v[7:0]};
            8'h18: r = {9'h0, v[7], v[6], v[5], v[2], v[1:0] == 2'h2, v[1:0] == 2'h1,
                        v[1:0] == 2'h3, v[15:0] & 16'h00e7};
            8'h1c: r = {23'h0, v[0], 7'h00, v[0]};
            8'h20: r = {23'h0, v[7:0] == 8'h02, v[7:0]};
            8'h30: r = {23'h0, opt_cnt, opt_end};
            8'h34: begin
                r[20:0] = v[20:0];
                r[21] = v[11:10] == 2'h2;
                r[28:24] = r[21] ? 5'h02 : 5'h02 + n[5:1];
            end
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Bus and checking
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            $display("[FAIL] ack wait ran out");
            final_report();
        end
        rd_q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        check("ack_drop", {31'h0, wb_ack_o}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] m;
        m = wmask(a) & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        wb(1'b1, a, s, d);
        if (a == 8'h2c && s[0] && !opt_end) begin
            if (d[7:0] != 8'h00) opt_cnt++;
            else opt_end = 1'b1;
        end
        if (a == 8'h30 && s[0] && d[0]) begin
            opt_cnt = 8'h00;
            opt_end = 1'b0;
        end
        if (wmask(a) != 32'h0) sh[a[5:2]] = (sh[a[5:2]] & ~m) | (d & m);
    endtask

    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 4'hf, 32'h0);
        check($sformatf("read_%02h", a), rd_q, exp_read(a));
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {next_r, last_r, opt_end, opt_cnt} = '0;
        rst_i = 1'b1;
        seed = 32'h0001_5b7d;
        for (int i = 0; i < 16; i++) sh[i] = 32'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 16; a++) rd(8'(a * 4));
        for (int l = 0; l < 16; l++) begin
            seed = lfsr(seed);
            wr(8'h00, 4'h1, {30'h0, 2'(l)});
            wr(8'h04, 4'hf, {seed[31:4], 4'(l)});
            rd(8'h0c);
            rd(8'h08);
            wr(8'h14, 4'h1, {24'h0, l[3], 4'h0, l[2:0]});
            rd(8'h14);
            wr(8'h20, 4'h1, {24'h0, l[3], 5'h00, l[1:0]});
            rd(8'h20);
            wr(8'h18, 4'h3, seed);
            rd(8'h18);
            wr(8'h34, 4'h7, {11'h0, l[1] ? 4'hf : 4'h0, l[0], 4'h0, l[2] ? 2'h2 : 2'(l), 10'h0});
            rd(8'h34);
        end
        for (int k = 0; k < 40; k++) begin
            seed = lfsr(seed);
            next_r <= 1'b1;
            wr(8'h10, seed[3:0], {seed[31:16], fci_w});
            next_r <= 1'b0;
            wr(8'h14, 4'h1, {24'h0, evt_w});
            wr(8'h1c, 4'h1, {24'h0, cont_w});
            rd(8'h10);
            rd(8'h1c);
            wr(8'({seed[7:4], 2'b00}), seed[11:8], lfsr(seed));
            rd(8'({seed[15:12], 2'b00}));
        end
        wr(8'h30, 4'h1, 32'h0000_0001);
        rd(8'h30);
        for (int k = 0; k < 7; k++) begin
            next_r <= 1'b1;
            last_r <= (k == 5);
            @(posedge clk_i);
            next_r <= 1'b0;
            wr(8'h2c, 4'h1, {24'h0, opt_w});
            rd(8'h30);
        end
        rd(8'h2c);
        wr(8'h30, 4'h1, 32'h0000_0001);
        rd(8'h30);
        final_report();
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        $display("[FAIL] run limit reached");
        final_report();
    end
endmodule
